//--- hdl/pvs_pcm_slot_if.sv
// pcm voice slot interface: axi4-lite registers and bit-clock side framing
//
// Notes on behaviour
// - master drives bit clock and sync; slave takes both as inputs.
// - up to three full-duplex channels, each placed on any of slots 0 to 15.
// - slots per frame follow interface rate and 4, 8 or 16 kHz sampling.
// - a channel transmits and receives in the same slot position.
// - data output is high impedance on slots with no active channel.
// - output released after falling bit clock inside a slot's last bit.
// - transparent wideband passes host words unchanged; 4 kHz, 16 bits.
// - on-chip wideband exchanges linear 16-bit samples at 16 kHz.
// - short or long sync selectable in master and slave roles.
// - short sync is one bit period high, rising-edge aligned, 8 kHz.
// - slave sees short sync at falling edge; next rise starts slot 0.
// - long sync is three bit periods high, starting with slot 0 bit 0.
// - 13 significant bits per 16-bit word, position and order set.
// - spare bits ignored on receive; filled by selected pattern.
// - reset format is 13-bit two's complement, left justified, msb first.
`timescale 1ns/1ns
`default_nettype none

module pvs_pcm_slot_if
   import pvs_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link clock, oversamples the bit clock
   input wire logic linkClk,
   // pcm pins
   input wire logic bclkIn,
   output logic bclkOut,
   output logic bclkOe,
   input wire logic syncIn,
   output logic syncOut,
   output logic syncOe,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOe
);

   // ==========================================================
   // functions
   function automatic logic [31:0] strbMerge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] strb,
      input logic [31:0] mask);
      logic [31:0] w;
      w = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            w[b*8 +: 8] = din[b*8 +: 8];
         end
      end
      return w & mask;
   endfunction : strbMerge

   function automatic logic [8:0] frameLast(input pvs_ctrl_t c);
      logic [9:0] base;
      logic [2:0] r;
      r = (c.rateSel > PVS_RATE_MAX) ? PVS_RATE_MAX : c.rateSel;
      case (c.fsSel)
         PVS_FS_16K: base = PVS_FB_16K;
         PVS_FS_4K: base = PVS_FB_4K;
         default: base = PVS_FB_8K;
      endcase
      base = base << r;
      return 9'(base - 10'h001);
   endfunction : frameLast

   // lowest channel wins a shared slot
   function automatic logic [2:0] slotHit(input pvs_slot_t s,
      input logic [4:0] idx);
      logic [2:0] r;
      r = '0;
      for (int c = PVS_NCH - 1; c >= 0; c--) begin
         if (s.en[c] && {1'b0, s.num[c]} == idx) begin
            r = {1'b1, 2'(c)};
         end
      end
      return r;
   endfunction : slotHit

   function automatic logic [15:0] bitRev(input logic [15:0] w);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < PVS_SLOT_BITS; i++) begin
         r[i] = w[PVS_SLOT_BITS - 1 - i];
      end
      return r;
   endfunction : bitRev

   function automatic logic [15:0] packTx(input pvs_cfg_t c,
      input logic [1:0] ch);
      logic [15:0] s;
      logic [2:0] fill;
      logic [15:0] w;
      s = c.tx[ch][15:0];
      w = s;
      if (c.ctrl.mode == PVS_MODE_NARROW) begin
         case (c.fmt.fillMode)
            PVS_FILL_ONES: fill = '1;
            PVS_FILL_SIGN: fill = {3{s[PVS_SIGN_BIT]}};
            PVS_FILL_PROG: fill = c.fmt.fillVal;
            default: fill = '0;
         endcase
         w = c.fmt.rightJust ? {fill, s[PVS_SIGN_BIT:0]}
                             : {s[PVS_SIGN_BIT:0], fill};
         if (c.fmt.lsbFirst) begin
            w = bitRev(w);
         end
      end
      return w;
   endfunction : packTx

   function automatic logic [15:0] unpackRx(input pvs_cfg_t c,
      input logic [15:0] raw);
      logic [15:0] w;
      logic [12:0] s;
      w = raw;
      // linear 16-bit samples kept whole in both wideband modes
      if (c.ctrl.mode == PVS_MODE_NARROW) begin
         if (c.fmt.lsbFirst) begin
            w = bitRev(w);
         end
         s = c.fmt.rightJust ? w[PVS_SIGN_BIT:0] : w[15:3];
         w = {{3{s[PVS_SIGN_BIT]}}, s};
      end
      return w;
   endfunction : unpackRx

   // ==========================================================
   // system side registers
   pvs_ctrl_t ctrl;
   logic [31:0] div;
   pvs_slot_t slots;
   pvs_fmt_t fmt;
   logic [2:0][31:0] tx;
   logic [2:0][15:0] rxData;
   logic [2:0] rxNew;
   logic [2:0] rxClr;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awHeld;
   logic wHeld;
   logic doWrite;
   logic [31:0] next_rdata;
   logic next_rdOk;
   logic cfgReq;
   pvs_cfg_t cfgXfer;
   logic ackS1;
   logic ackS2;
   logic [2:0] rxT1;
   logic [2:0] rxT2;
   logic [2:0] rxT3;
   logic [2:0] rxChg;
   logic runS1;
   logic runS2;

   // link side state
   logic lrst1;
   logic lrstN;
   logic bs1, bs2, bs3;
   logic ss1, ss2;
   logic ds1, ds2;
   logic rq1, rq2;
   logic ack;
   pvs_cfg_t cfgL;
   pvs_lstate_t lstate;
   logic [15:0] divCnt;
   logic riseEv;
   logic fallEv;
   logic [8:0] bitCnt;
   logic [8:0] lastBit;
   logic [8:0] nxt;
   logic syncPrev;
   logic cfgTake;
   logic [2:0] hitTx;
   logic [2:0] hitRx;
   logic [15:0] rxShift;
   logic [2:0][15:0] rxHold;
   logic [2:0] rxTog;
   logic [15:0] txWord;
   logic rxStb;
   logic rxUse;
   logic [2:0] rxTag;
   logic [1:0] rxDly;
   logic [1:0][2:0] rxDlyTag;

   // ==========================================================
   // axi4-lite write channel
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PVS_AXI_OKAY;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awAddr)
               PVS_ADDR_CTRL, PVS_ADDR_DIV, PVS_ADDR_SLOT, PVS_ADDR_FMT,
               PVS_ADDR_TX0, PVS_ADDR_TX1, PVS_ADDR_TX2:
                  s_axi_bresp <= PVS_AXI_OKAY;
               default: s_axi_bresp <= PVS_AXI_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= pvs_ctrl_t'(PVS_CTRL_RST);
         div <= PVS_DIV_RST;
         slots <= pvs_slot_t'(PVS_SLOT_RST);
         fmt <= pvs_fmt_t'(PVS_FMT_RST);
         tx <= '0;
      end else if (doWrite) begin
         case (awAddr)
            PVS_ADDR_CTRL:
               ctrl <= strbMerge(ctrl, wData, wStrb, PVS_CTRL_MASK);
            PVS_ADDR_DIV: div <= strbMerge(div, wData, wStrb, PVS_DIV_MASK);
            PVS_ADDR_SLOT:
               slots <= strbMerge(slots, wData, wStrb, PVS_SLOT_MASK);
            PVS_ADDR_FMT: fmt <= strbMerge(fmt, wData, wStrb, PVS_FMT_MASK);
            PVS_ADDR_TX0:
               tx[0] <= strbMerge(tx[0], wData, wStrb, PVS_TX_MASK);
            PVS_ADDR_TX1:
               tx[1] <= strbMerge(tx[1], wData, wStrb, PVS_TX_MASK);
            PVS_ADDR_TX2:
               tx[2] <= strbMerge(tx[2], wData, wStrb, PVS_TX_MASK);
            default: ;
         endcase
      end
   end

   // ==========================================================
   // axi4-lite read channel
   always_comb begin
      next_rdOk = 1'b1;
      rxClr = '0;
      case (s_axi_araddr)
         PVS_ADDR_CTRL: next_rdata = ctrl;
         PVS_ADDR_DIV: next_rdata = div;
         PVS_ADDR_SLOT: next_rdata = slots;
         PVS_ADDR_FMT: next_rdata = fmt;
         PVS_ADDR_TX0: next_rdata = tx[0];
         PVS_ADDR_TX1: next_rdata = tx[1];
         PVS_ADDR_TX2: next_rdata = tx[2];
         PVS_ADDR_RX0: begin
            next_rdata = {16'h0000, rxData[0]};
            rxClr[0] = 1'b1;
         end
         PVS_ADDR_RX1: begin
            next_rdata = {16'h0000, rxData[1]};
            rxClr[1] = 1'b1;
         end
         PVS_ADDR_RX2: begin
            next_rdata = {16'h0000, rxData[2]};
            rxClr[2] = 1'b1;
         end
         PVS_ADDR_STATUS:
            next_rdata = pvs_status_t'{zero: '0, busy: ackS2 != cfgReq,
               run: runS2, rxNew: rxNew};
         default: begin
            next_rdata = '0;
            next_rdOk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= PVS_AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rdOk ? PVS_AXI_OKAY : PVS_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // crossings seen from the system side
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfgReq <= 1'b0;
         cfgXfer <= '0;
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
      end else begin
         ackS1 <= ack;
         ackS2 <= ackS1;
         // snapshot held stable until the link side acknowledges it
         if (ackS2 == cfgReq) begin
            cfgXfer <= '{ctrl: ctrl, div: div, slots: slots, fmt: fmt,
               tx: tx};
            cfgReq <= !cfgReq;
         end
      end
   end

   assign rxChg = rxT2 ^ rxT3;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxT1 <= '0;
         rxT2 <= '0;
         rxT3 <= '0;
         rxData <= '0;
         rxNew <= '0;
         runS1 <= 1'b0;
         runS2 <= 1'b0;
      end else begin
         rxT1 <= rxTog;
         rxT2 <= rxT1;
         rxT3 <= rxT2;
         runS1 <= lstate == PVS_L_RUN;
         runS2 <= runS1;
         for (int c = 0; c < PVS_NCH; c++) begin
            if (rxChg[c]) begin
               rxData[c] <= rxHold[c];
            end
         end
         // a new word beats a read-clear in the same cycle
         rxNew <= (rxNew & ~(rxClr & {3{s_axi_arvalid && s_axi_arready}}))
            | rxChg;
      end
   end

   // ==========================================================
   // link domain: reset, pin and request synchronisers
   always_ff @(posedge linkClk) begin
      lrst1 <= rst_n;
      lrstN <= lrst1;
      bs1 <= bclkIn;
      bs2 <= bs1;
      bs3 <= bs2;
      ss1 <= syncIn;
      ss2 <= ss1;
      ds1 <= dataIn;
      ds2 <= ds1;
   end

   assign lastBit = frameLast(cfgL.ctrl);
   assign nxt = (bitCnt >= lastBit) ? 9'h000 : 9'(bitCnt + 9'h001);
   // settings change only between frames
   assign cfgTake = (rq2 != ack)
      && (lstate != PVS_L_RUN || (fallEv && bitCnt == lastBit));

   always_ff @(posedge linkClk) begin
      if (!lrstN) begin
         rq1 <= 1'b0;
         rq2 <= 1'b0;
         ack <= 1'b0;
         cfgL <= '0;
      end else begin
         rq1 <= cfgReq;
         rq2 <= rq1;
         if (cfgTake) begin
            cfgL <= cfgXfer;
            ack <= rq2;
         end
      end
   end

   // ==========================================================
   // bit clock: own divider as master, sampled edges as slave
   always_comb begin
      if (cfgL.ctrl.master) begin
         riseEv = lstate != PVS_L_IDLE && divCnt == '0 && !bclkOut;
         fallEv = lstate != PVS_L_IDLE && divCnt == '0 && bclkOut;
      end else begin
         riseEv = bs2 && !bs3;
         fallEv = !bs2 && bs3;
      end
   end

   always_ff @(posedge linkClk) begin
      if (!lrstN || lstate == PVS_L_IDLE) begin
         divCnt <= '0;
         bclkOut <= 1'b0;
      end else if (divCnt == '0) begin
         divCnt <= cfgL.div[15:0];
         bclkOut <= !bclkOut;
      end else begin
         divCnt <= divCnt - 16'h0001;
      end
   end

   // bit clock and sync pins driven only in master role
   always_ff @(posedge linkClk) begin
      if (!lrstN) begin
         bclkOe <= 1'b0;
         syncOe <= 1'b0;
      end else begin
         bclkOe <= cfgL.ctrl.enable && cfgL.ctrl.master;
         syncOe <= cfgL.ctrl.enable && cfgL.ctrl.master;
      end
   end

   // ==========================================================
   // frame position
   always_ff @(posedge linkClk) begin
      if (!lrstN) begin
         lstate <= PVS_L_IDLE;
         bitCnt <= '0;
         syncPrev <= 1'b0;
      end else begin
         case (lstate)
            PVS_L_IDLE: begin
               bitCnt <= lastBit;
               syncPrev <= 1'b0;
               if (cfgL.ctrl.enable) begin
                  lstate <= cfgL.ctrl.master ? PVS_L_RUN : PVS_L_HUNT;
               end
            end
            PVS_L_HUNT, PVS_L_RUN: begin
               if (!cfgL.ctrl.enable) begin
                  lstate <= PVS_L_IDLE;
               end else if (riseEv) begin
                  bitCnt <= nxt;
               end else if (fallEv && !cfgL.ctrl.master) begin
                  syncPrev <= ss2;
                  // short sync: next rise is bit 0
                  if (!cfgL.ctrl.longSync && ss2) begin
                     bitCnt <= lastBit;
                     lstate <= PVS_L_RUN;
                  end
                  // long sync: current bit is bit 0
                  if (cfgL.ctrl.longSync && ss2 && !syncPrev) begin
                     bitCnt <= '0;
                     lstate <= PVS_L_RUN;
                  end
               end
               // a new frame length starts cleanly at the next rise
               if (lstate == PVS_L_RUN && cfgTake) begin
                  bitCnt <= frameLast(cfgXfer.ctrl);
               end
            end
            default: lstate <= PVS_L_IDLE;
         endcase
      end
   end

   // ==========================================================
   // master frame sync
   always_ff @(posedge linkClk) begin
      if (!lrstN || lstate != PVS_L_RUN || !cfgL.ctrl.master) begin
         syncOut <= 1'b0;
      end else if (riseEv) begin
         syncOut <= cfgL.ctrl.longSync ? (nxt < PVS_LONG_SYNC_BITS)
                                       : (nxt == lastBit);
      end
   end

   // ==========================================================
   // transmit data
   assign hitTx = slotHit(cfgL.slots, nxt[8:4]);
   assign txWord = packTx(cfgL, hitTx[1:0]);

   always_ff @(posedge linkClk) begin
      if (!lrstN || lstate != PVS_L_RUN) begin
         dataOe <= 1'b0;
         dataOut <= 1'b0;
      end else if (riseEv) begin
         // drive only inside an assigned slot
         dataOe <= hitTx[2];
         dataOut <= hitTx[2] && txWord[PVS_BIT_LAST - nxt[3:0]];
      end else if (fallEv && bitCnt[3:0] == PVS_BIT_LAST) begin
         dataOe <= 1'b0;
         dataOut <= 1'b0;
      end
   end

   // ==========================================================
   // receive data
   assign hitRx = slotHit(cfgL.slots, bitCnt[8:4]);
   assign rxStb = lstate == PVS_L_RUN && fallEv && hitRx[2];
   // as master, data returns through two flops after our own edge
   assign rxUse = cfgL.ctrl.master ? rxDly[1] : rxStb;
   assign rxTag = cfgL.ctrl.master ? rxDlyTag[1]
      : {hitRx[1:0], bitCnt[3:0] == PVS_BIT_LAST};

   always_ff @(posedge linkClk) begin
      if (!lrstN) begin
         rxDly <= '0;
         rxDlyTag <= '0;
      end else begin
         rxDly <= {rxDly[0], rxStb};
         rxDlyTag <= {rxDlyTag[0], hitRx[1:0], bitCnt[3:0] == PVS_BIT_LAST};
      end
   end

   always_ff @(posedge linkClk) begin
      if (!lrstN) begin
         rxShift <= '0;
         rxHold <= '0;
         rxTog <= '0;
      end else if (rxUse) begin
         rxShift <= {rxShift[14:0], ds2};
         if (rxTag[0]) begin
            rxHold[rxTag[2:1]] <= unpackRx(cfgL, {rxShift[14:0], ds2});
            rxTog[rxTag[2:1]] <= !rxTog[rxTag[2:1]];
         end
      end
   end

endmodule : pvs_pcm_slot_if

`default_nettype wire

//--- shared/pvs_pkg.sv
// constants, register layouts and carrier types for the pcm voice slot block
package pvs_pkg;

   // ==========================================================
   // register byte addresses
   localparam logic [7:0] PVS_ADDR_CTRL = 8'h00;
   localparam logic [7:0] PVS_ADDR_DIV = 8'h04;
   localparam logic [7:0] PVS_ADDR_SLOT = 8'h08;
   localparam logic [7:0] PVS_ADDR_FMT = 8'h0C;
   localparam logic [7:0] PVS_ADDR_STEP = 8'h04;
   localparam logic [7:0] PVS_ADDR_TX0 = 8'h10;
   localparam logic [7:0] PVS_ADDR_TX1 = PVS_ADDR_TX0 + PVS_ADDR_STEP;
   localparam logic [7:0] PVS_ADDR_TX2 = PVS_ADDR_TX1 + PVS_ADDR_STEP;
   localparam logic [7:0] PVS_ADDR_RX0 = 8'h20;
   localparam logic [7:0] PVS_ADDR_RX1 = PVS_ADDR_RX0 + PVS_ADDR_STEP;
   localparam logic [7:0] PVS_ADDR_RX2 = PVS_ADDR_RX1 + PVS_ADDR_STEP;
   localparam logic [7:0] PVS_ADDR_STATUS = 8'h2C;

   // ==========================================================
   // writable bits and reset values
   localparam logic [31:0] PVS_CTRL_MASK = 32'h0000_03FF;
   localparam logic [31:0] PVS_DIV_MASK = 32'h0000_FFFF;
   localparam logic [31:0] PVS_SLOT_MASK = 32'h0000_7FFF;
   localparam logic [31:0] PVS_FMT_MASK = 32'h0000_007F;
   localparam logic [31:0] PVS_TX_MASK = 32'h0000_FFFF;
   localparam logic [31:0] PVS_CTRL_RST = 32'h0000_0082;
   localparam logic [31:0] PVS_DIV_RST = 32'h0000_0001;
   localparam logic [31:0] PVS_SLOT_RST = 32'h0000_0000;
   localparam logic [31:0] PVS_FMT_RST = 32'h0000_0000;

   // ==========================================================
   // field encodings
   localparam logic [1:0] PVS_FS_8K = 2'h0;
   localparam logic [1:0] PVS_FS_16K = 2'h1;
   localparam logic [1:0] PVS_FS_4K = 2'h2;
   localparam logic [1:0] PVS_MODE_NARROW = 2'h0;
   localparam logic [1:0] PVS_MODE_WB_TRANSP = 2'h1;
   localparam logic [1:0] PVS_MODE_WB_ONCHIP = 2'h2;
   localparam logic [1:0] PVS_FILL_ZERO = 2'h0;
   localparam logic [1:0] PVS_FILL_ONES = 2'h1;
   localparam logic [1:0] PVS_FILL_SIGN = 2'h2;
   localparam logic [1:0] PVS_FILL_PROG = 2'h3;
   localparam logic [2:0] PVS_RATE_MAX = 3'h4;
   localparam logic [1:0] PVS_AXI_OKAY = 2'h0;
   localparam logic [1:0] PVS_AXI_SLVERR = 2'h2;

   // ==========================================================
   // framing constants
   localparam int PVS_NCH = 3;
   localparam int PVS_SLOT_BITS = 16;
   localparam int PVS_SIGN_BIT = 12;
   localparam logic [3:0] PVS_BIT_LAST = 4'hF;
   localparam logic [8:0] PVS_LONG_SYNC_BITS = 9'h003;
   localparam logic [9:0] PVS_FB_8K = 10'h010;
   localparam logic [9:0] PVS_FB_16K = 10'h008;
   localparam logic [9:0] PVS_FB_4K = 10'h020;

   // ==========================================================
   // register layouts and carriers
   typedef struct packed {
      logic [21:0] zero;
      logic [1:0] mode;
      logic [2:0] rateSel;
      logic [1:0] fsSel;
      logic longSync;
      logic master;
      logic enable;
   } pvs_ctrl_t;

   typedef struct packed {
      logic [16:0] zero;
      logic [2:0] en;
      logic [2:0][3:0] num;
   } pvs_slot_t;

   typedef struct packed {
      logic [24:0] zero;
      logic [2:0] fillVal;
      logic [1:0] fillMode;
      logic lsbFirst;
      logic rightJust;
   } pvs_fmt_t;

   typedef struct packed {
      logic [26:0] zero;
      logic busy;
      logic run;
      logic [2:0] rxNew;
   } pvs_status_t;

   typedef struct packed {
      pvs_ctrl_t ctrl;
      logic [31:0] div;
      pvs_slot_t slots;
      pvs_fmt_t fmt;
      logic [2:0][31:0] tx;
   } pvs_cfg_t;

   typedef enum logic [2:0] {
      PVS_L_IDLE = 3'b001,
      PVS_L_HUNT = 3'b010,
      PVS_L_RUN = 3'b100
   } pvs_lstate_t;

endpackage : pvs_pkg

//--- test/pvs_checker.sv
// concurrent checks on the pcm voice slot block ports
`timescale 1ns/1ns
`default_nettype none
module pvs_checker (
   // system side
   input wire logic clk, rst_n, s_axi_awvalid, s_axi_awready,
   input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid,
   input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic s_axi_rvalid, s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // link side
   input wire logic linkClk, bclkOut, bclkOe, syncOut, syncOe, dataOe
);
   // ====
   // bus checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("bvalid dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during read answer");
   // ====
   // pin checks
   a_pin_roles: assert property (@(posedge linkClk) bclkOe == syncOe)
      else $error("clock and sync roles differ");
   a_oe_start: assert property (@(posedge linkClk)
      $rose(dataOe) && bclkOe |-> $rose(bclkOut)) else $error("oe rise");
   a_oe_release: assert property (@(posedge linkClk)
      $fell(dataOe) && bclkOe |-> $fell(bclkOut)) else $error("oe fall");
   a_sync_edge: assert property (@(posedge linkClk)
      $changed(syncOut) && syncOe |-> $rose(bclkOut)) else $error("sync");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (@(posedge linkClk) $fell(dataOe));
   cover property (@(posedge linkClk) $rose(syncOut));
endmodule : pvs_checker
bind pvs_pcm_slot_if pvs_checker chk (.*);
`default_nettype wire

//--- test/pvs_codec_model.sv
// linear codec model on the far side of the pcm pins
`timescale 1ns/1ns
`default_nettype none
module pvs_codec_model (
   // pins and word to send
   input wire logic bclk, sync,
   input wire logic [15:0] word,
   output logic sd
);
   logic [4:0] cnt = 5'h10;
   logic seen = 1'b0;
   initial sd = 1'b0;
   always @(negedge bclk) seen <= sync;
   always @(posedge bclk) begin
      if (seen) begin
         sd <= word[15];
         cnt <= 5'h1;
      end else if (cnt < 5'h10) begin
         sd <= word[4'hF - cnt[3:0]];
         cnt <= cnt + 5'h1;
      end else sd <= ~sd;
   end
endmodule : pvs_codec_model
`default_nettype wire

//--- test/pcm_voice_slot_interface_tb.sv
// self-checking bench for the pcm voice slot block
`timescale 1ns/1ns
`default_nettype none
module pcm_voice_slot_interface_tb
   import pvs_pkg::*;
;
   localparam logic [12:0] SMP = 13'h1ABC;
   logic clk = 0, rst_n = 0, linkClk = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, bclkOut, bclkOe, syncOut, syncOe, dataOut, dataOe;
   logic dataIn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] rxWord = 16'hA5AF;
   int miscompares = 0, checks = 0;
   wire bclkIn = bclkOe & bclkOut;
   wire syncIn = syncOe & syncOut;
   pvs_pcm_slot_if uut (.*);
   pvs_codec_model codec (.bclk(bclkIn), .sync(syncIn), .word(rxWord),
      .sd(dataIn));
   always #5 clk = ~clk;
   always begin
      #7 linkClk = 1;
      #8 linkClk = 0;
   end
   // ====
   // tasks
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         #1;
      end while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge clk); while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask : rd
   task automatic grab(input int sk, input logic [15:0] e);
      logic [15:0] w;
      repeat (2) @(posedge syncOut);
      @(negedge bclkOut);
      repeat (sk) begin
         @(posedge bclkOut);
         @(posedge linkClk);
         chk({31'h0, dataOe}, 32'h0);
      end
      repeat (16) begin
         @(posedge bclkOut);
         @(posedge linkClk);
         w = {w[14:0], dataOut};
      end
      chk({16'h0, w}, {16'h0, e});
   endtask : grab
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // ====
   // tests
   initial begin
      #100000;
      miscompares++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(PVS_ADDR_FMT, PVS_FMT_RST, PVS_AXI_OKAY);
      rd(PVS_ADDR_CTRL, PVS_CTRL_RST, PVS_AXI_OKAY);
      rd(8'h30, 32'h0, PVS_AXI_SLVERR);
      wr(8'h30, 32'h1, PVS_AXI_SLVERR);
      wr(PVS_ADDR_FMT, 32'hFFFF_FFFF, PVS_AXI_OKAY);
      rd(PVS_ADDR_FMT, PVS_FMT_MASK, PVS_AXI_OKAY);
      wr(PVS_ADDR_FMT, 32'h0, PVS_AXI_OKAY);
      wr(PVS_ADDR_SLOT, 32'h0000_1000, PVS_AXI_OKAY);
      wr(PVS_ADDR_TX0, {19'h0, SMP}, PVS_AXI_OKAY);
      wr(PVS_ADDR_CTRL, 32'h0000_0003, PVS_AXI_OKAY);
      grab(0, {SMP, 3'h0});
      rd(PVS_ADDR_RX0, {16'h0, {3{rxWord[15]}}, rxWord[15:3]}, 2'h0);
      for (int m = 1; m < 4; m++) begin
         wr(PVS_ADDR_FMT, 32'h50 + 32'(m * 4), PVS_AXI_OKAY);
         grab(0, {SMP, (m == 3) ? 3'h5 : 3'h7});
      end
      wr(PVS_ADDR_FMT, 32'h3, PVS_AXI_OKAY);
      grab(0, 16'({<<{3'h0, SMP}}));
      wr(PVS_ADDR_CTRL, 32'h0000_0103, PVS_AXI_OKAY);
      grab(0, {3'h0, SMP});
      wr(PVS_ADDR_CTRL, 32'h0000_0203, PVS_AXI_OKAY);
      grab(0, {3'h0, SMP});
      rd(PVS_ADDR_RX0, {16'h0, rxWord}, PVS_AXI_OKAY);
      wr(PVS_ADDR_FMT, 32'h0, PVS_AXI_OKAY);
      wr(PVS_ADDR_SLOT, 32'h0000_1001, PVS_AXI_OKAY);
      wr(PVS_ADDR_CTRL, 32'h0000_0023, PVS_AXI_OKAY);
      grab(16, {SMP, 3'h0});
      end_sim;
   end
endmodule : pcm_voice_slot_interface_tb
`default_nettype wire
